// *** hdl/rpt_pkg.sv ***
`default_nettype none
package rpt_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TOGGLE_MIN_NS = 62000;
  localparam int TOGGLE_MIN_CYC = (TOGGLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HI_CNT_W = 10;
  localparam int STARTUP_CYC_DEF = 16;

  // input identifiers
  localparam logic [7:0] TXT_SET_PORT = 8'h64;
  localparam logic [7:0] TXT_NAV_XYZ = 8'h65;
  localparam logic [7:0] TXT_CORR_PORT = 8'h66;
  localparam logic [7:0] TXT_RATE = 8'h67;
  localparam logic [7:0] TXT_NAV_LLA = 8'h68;
  localparam logic [7:0] TXT_DEV_DATA = 8'h69;
  localparam logic [7:0] TXT_DATUM = 8'h6a;
  localparam logic [7:0] TXT_EE_PROP1 = 8'h6b;
  localparam logic [7:0] TXT_EE_PROP2 = 8'h6c;
  localparam logic [7:0] TXT_EE_DEBUG = 8'h6e;
  localparam logic [7:0] BIN_SBAS_CTRL = 8'h85;

  // output report identifiers
  localparam logic [7:0] OUT_NAV = 8'h02;
  localparam logic [7:0] OUT_TRACK = 8'h04;
  localparam logic [7:0] OUT_ERROR = 8'h0a;
  localparam logic [7:0] OUT_ACK = 8'h0b;
  localparam logic [7:0] OUT_NAK = 8'h0c;
  localparam logic [7:0] OUT_VISIBLE = 8'h0d;
  localparam logic [7:0] OUT_CORR = 8'h11;
  localparam logic [7:0] OUT_READY = 8'h12;
  localparam logic [7:0] OUT_CORR_STAT = 8'h1b;
  localparam logic [7:0] OUT_GEO = 8'h29;
  localparam logic [7:0] OUT_SBAS = 8'h32;
  localparam logic [7:0] OUT_PPS = 8'h34;

  // pending report slots, lower index sent first
  localparam int NPEND = 12;
  localparam int P_ERR = 0;
  localparam int P_ACK = 1;
  localparam int P_NAK = 2;
  localparam int P_READY = 3;
  localparam int P_PPS = 4;
  localparam int P_SBAS = 5;
  localparam int P_NAV = 6;
  localparam int P_GEO = 7;
  localparam int P_TRACK = 8;
  localparam int P_VISIBLE = 9;
  localparam int P_CORR = 10;
  localparam int P_CORR_STAT = 11;

  typedef enum logic [2:0] {
    ST_HIB = 3'h1,
    ST_BOOT = 3'h2,
    ST_READY = 3'h4
  } rpt_state_t;

  typedef enum logic [3:0] {
    CLS_NONE = 4'h0,
    CLS_SET_PORT = 4'h1,
    CLS_NAV_XYZ = 4'h2,
    CLS_CORR_PORT = 4'h3,
    CLS_RATE = 4'h4,
    CLS_NAV_LLA = 4'h5,
    CLS_DEV_DATA = 4'h6,
    CLS_DATUM = 4'h7,
    CLS_EE_PROP = 4'h8,
    CLS_EE_DEBUG = 4'h9,
    CLS_BEACON = 4'ha,
    CLS_SBAS_ON = 4'hb
  } rpt_class_t;

  typedef struct packed {
    logic binary;
    logic beacon;
    logic [7:0] id;
  } rpt_cmd_t;
endpackage
`default_nettype wire

// *** hdl/rpt_buf2.sv ***
`default_nettype none
module rpt_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // async reset
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // head word present
  input wire logic out_ready, // reader takes head
  output logic [WIDTH-1:0] out_data // head word
);
  logic [WIDTH-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid & (cnt_r != 2'h2);
    pop = out_valid & out_ready;
    d0_nxt = d0_r;
    d1_nxt = d1_r;
    cnt_nxt = cnt_r;
    if (push && pop) begin
      if (cnt_r == 2'h1) begin
        d0_nxt = in_data;
      end else begin
        d0_nxt = d1_r;
        d1_nxt = in_data;
      end
    end else if (pop) begin
      d0_nxt = d1_r;
      cnt_nxt = cnt_r - 2'h1;
    end else if (push) begin
      if (cnt_r == 2'h0) begin
        d0_nxt = in_data;
      end else begin
        d1_nxt = in_data;
      end
      cnt_nxt = cnt_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      d0_r <= '0;
      d1_r <= '0;
      cnt_r <= 2'h0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != 2'h2);
      out_valid <= (cnt_nxt != 2'h0);
    end
  end

  assign out_data = d0_r;
endmodule
`default_nettype wire

// *** hdl/rpt_power_seq.sv ***
`default_nettype none
module rpt_power_seq #(
  parameter int STARTUP_CYC = rpt_pkg::STARTUP_CYC_DEF
) (
  input wire logic core_clk, // 10 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic power_toggle, // toggle pin from host, asynchronous
  output logic wake_indication_output, // high in full power
  input wire logic cmd_valid, // host command present
  output logic cmd_ready, // command can be taken
  input wire rpt_pkg::rpt_cmd_t cmd_in, // protocol, beacon flag, identifier
  output rpt_pkg::rpt_class_t cmd_class, // decoded class of last command taken while ready
  output logic cmd_class_vld, // one-cycle pulse with cmd_class
  output logic sbas_enabled, // augmentation corrections applied
  input wire logic fix_evt, // navigation solution ready
  input wire logic track_evt, // tracking update ready
  input wire logic pps_evt, // pulse-per-second epoch
  input wire logic corr_evt, // correction broadcast received
  output logic rpt_valid, // report identifier present
  input wire logic rpt_ready, // host side takes report
  output logic [7:0] rpt_id // report identifier
);
  localparam logic [rpt_pkg::HI_CNT_W-1:0] HI_MIN = rpt_pkg::HI_CNT_W'(rpt_pkg::TOGGLE_MIN_CYC);
  localparam logic [15:0] BOOT_LAST = 16'(STARTUP_CYC - 1);

  rpt_pkg::rpt_state_t state_r, state_nxt;
  logic tog_meta_r, tog_sync_r, tog_prev_r;
  logic [rpt_pkg::HI_CNT_W-1:0] hi_cnt_r, hi_cnt_nxt;
  logic [15:0] boot_cnt_r, boot_cnt_nxt;
  logic [rpt_pkg::NPEND-1:0] pend_r, pend_nxt, pend_set, pend_clr;
  logic wake_r, wake_nxt;
  logic cmd_ready_r, cmd_ready_nxt;
  logic sbas_r, sbas_nxt;
  rpt_pkg::rpt_class_t cls_r, cls_nxt;
  logic cls_vld_r, cls_vld_nxt;
  logic tog_fall, pulse_ok, cmd_take, is_ready;
  logic buf_in_ready;
  logic [7:0] push_id;
  int sel;

  function automatic rpt_pkg::rpt_class_t decode_text(input logic [7:0] id);
    unique case (id)
      rpt_pkg::TXT_SET_PORT: decode_text = rpt_pkg::CLS_SET_PORT;
      rpt_pkg::TXT_NAV_XYZ: decode_text = rpt_pkg::CLS_NAV_XYZ;
      rpt_pkg::TXT_CORR_PORT: decode_text = rpt_pkg::CLS_CORR_PORT;
      rpt_pkg::TXT_RATE: decode_text = rpt_pkg::CLS_RATE;
      rpt_pkg::TXT_NAV_LLA: decode_text = rpt_pkg::CLS_NAV_LLA;
      rpt_pkg::TXT_DEV_DATA: decode_text = rpt_pkg::CLS_DEV_DATA;
      rpt_pkg::TXT_DATUM: decode_text = rpt_pkg::CLS_DATUM;
      rpt_pkg::TXT_EE_PROP1, rpt_pkg::TXT_EE_PROP2: decode_text = rpt_pkg::CLS_EE_PROP;
      rpt_pkg::TXT_EE_DEBUG: decode_text = rpt_pkg::CLS_EE_DEBUG;
      default: decode_text = rpt_pkg::CLS_NONE;
    endcase
  endfunction

  function automatic logic [7:0] slot_id(input int idx);
    case (idx)
      rpt_pkg::P_ERR: slot_id = rpt_pkg::OUT_ERROR;
      rpt_pkg::P_ACK: slot_id = rpt_pkg::OUT_ACK;
      rpt_pkg::P_NAK: slot_id = rpt_pkg::OUT_NAK;
      rpt_pkg::P_READY: slot_id = rpt_pkg::OUT_READY;
      rpt_pkg::P_PPS: slot_id = rpt_pkg::OUT_PPS;
      rpt_pkg::P_SBAS: slot_id = rpt_pkg::OUT_SBAS;
      rpt_pkg::P_NAV: slot_id = rpt_pkg::OUT_NAV;
      rpt_pkg::P_GEO: slot_id = rpt_pkg::OUT_GEO;
      rpt_pkg::P_TRACK: slot_id = rpt_pkg::OUT_TRACK;
      rpt_pkg::P_VISIBLE: slot_id = rpt_pkg::OUT_VISIBLE;
      rpt_pkg::P_CORR: slot_id = rpt_pkg::OUT_CORR;
      default: slot_id = rpt_pkg::OUT_CORR_STAT;
    endcase
  endfunction

  // pin synchroniser; the meta stage feeds only the sync stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
      tog_prev_r <= 1'b0;
    end else begin
      tog_meta_r <= power_toggle;
      tog_sync_r <= tog_meta_r;
      tog_prev_r <= tog_sync_r;
    end
  end

  assign tog_fall = tog_prev_r & ~tog_sync_r;
  // width judged at the falling edge, so a held-high pin never toggles twice
  assign pulse_ok = tog_fall && (hi_cnt_r >= HI_MIN);
  assign is_ready = (state_r == rpt_pkg::ST_READY);
  assign cmd_take = cmd_valid & cmd_ready_r;

  // power sequence
  always_comb begin
    state_nxt = state_r;
    boot_cnt_nxt = boot_cnt_r;
    hi_cnt_nxt = '0;
    if (tog_sync_r) begin
      hi_cnt_nxt = (hi_cnt_r == HI_MIN) ? hi_cnt_r : hi_cnt_r + 1'b1;
    end
    unique case (state_r)
      rpt_pkg::ST_HIB: begin
        if (pulse_ok) begin
          state_nxt = rpt_pkg::ST_BOOT;
          boot_cnt_nxt = '0;
        end
      end
      rpt_pkg::ST_BOOT: begin
        // toggles while booting are ignored; host waits for the ready report
        if (boot_cnt_r == BOOT_LAST) begin
          state_nxt = rpt_pkg::ST_READY;
        end else begin
          boot_cnt_nxt = boot_cnt_r + 16'h1;
        end
      end
      rpt_pkg::ST_READY: begin
        if (pulse_ok) begin
          state_nxt = rpt_pkg::ST_HIB;
        end
      end
    endcase
    wake_nxt = (state_nxt != rpt_pkg::ST_HIB);
  end

  // command decode and outcome
  always_comb begin
    sbas_nxt = sbas_r;
    cls_nxt = cls_r;
    cls_vld_nxt = 1'b0;
    pend_set = '0;
    if (state_r == rpt_pkg::ST_BOOT && state_nxt == rpt_pkg::ST_READY) begin
      pend_set[rpt_pkg::P_READY] = 1'b1;
    end
    if (cmd_take) begin
      if (!is_ready) begin
        pend_set[rpt_pkg::P_ERR] = 1'b1;
      end else begin
        cls_vld_nxt = 1'b1;
        if (cmd_in.beacon) begin
          cls_nxt = rpt_pkg::CLS_BEACON;
        end else if (cmd_in.binary) begin
          cls_nxt = (cmd_in.id == rpt_pkg::BIN_SBAS_CTRL) ? rpt_pkg::CLS_SBAS_ON
                                                          : rpt_pkg::CLS_NONE;
          if (cmd_in.id == rpt_pkg::BIN_SBAS_CTRL) begin
            sbas_nxt = 1'b1;
          end
        end else begin
          cls_nxt = decode_text(cmd_in.id);
        end
        if (cls_nxt == rpt_pkg::CLS_NONE) begin
          pend_set[rpt_pkg::P_NAK] = 1'b1;
        end else begin
          pend_set[rpt_pkg::P_ACK] = 1'b1;
        end
      end
    end
    // event reports are only raised while fully up and receptive; error and ready reports are raised outside it
    if (is_ready) begin
      pend_set[rpt_pkg::P_NAV] = pend_set[rpt_pkg::P_NAV] | fix_evt;
      pend_set[rpt_pkg::P_GEO] = pend_set[rpt_pkg::P_GEO] | fix_evt;
      pend_set[rpt_pkg::P_TRACK] = track_evt;
      pend_set[rpt_pkg::P_VISIBLE] = track_evt;
      pend_set[rpt_pkg::P_PPS] = pps_evt;
      pend_set[rpt_pkg::P_SBAS] = pps_evt & sbas_r;
      pend_set[rpt_pkg::P_CORR] = corr_evt;
      pend_set[rpt_pkg::P_CORR_STAT] = corr_evt;
    end
  end

  // pending reports drain lowest slot first into the buffer
  always_comb begin
    sel = 0;
    for (int i = rpt_pkg::NPEND - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        sel = i;
      end
    end
    push_id = slot_id(sel);
    pend_clr = '0;
    if ((|pend_r) && buf_in_ready) begin
      pend_clr[sel] = 1'b1;
    end
    // a new event in the clearing cycle survives: set wins
    pend_nxt = (pend_r & ~pend_clr) | pend_set;
    // one command outcome outstanding at a time keeps the reply order plain
    cmd_ready_nxt = ~(pend_nxt[rpt_pkg::P_ERR] | pend_nxt[rpt_pkg::P_ACK]
                      | pend_nxt[rpt_pkg::P_NAK]);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rpt_pkg::ST_HIB;
      hi_cnt_r <= '0;
      boot_cnt_r <= '0;
      pend_r <= '0;
      wake_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      sbas_r <= 1'b0;
      cls_r <= rpt_pkg::CLS_NONE;
      cls_vld_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      boot_cnt_r <= boot_cnt_nxt;
      pend_r <= pend_nxt;
      wake_r <= wake_nxt;
      cmd_ready_r <= cmd_ready_nxt;
      sbas_r <= sbas_nxt;
      cls_r <= cls_nxt;
      cls_vld_r <= cls_vld_nxt;
    end
  end

  rpt_buf2 #(
    .WIDTH(8)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(|pend_r),
    .in_ready(buf_in_ready),
    .in_data(push_id),
    .out_valid(rpt_valid),
    .out_ready(rpt_ready),
    .out_data(rpt_id)
  );

  assign wake_indication_output = wake_r;
  assign cmd_ready = cmd_ready_r;
  assign cmd_class = cls_r;
  assign cmd_class_vld = cls_vld_r;
  assign sbas_enabled = sbas_r;

  // power sequence
  a_wake_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    wake_r == (state_r != rpt_pkg::ST_HIB)) else $error("wake level wrong");
  a_short_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r == rpt_pkg::ST_HIB && tog_fall && hi_cnt_r < HI_MIN) |=>
    state_r == rpt_pkg::ST_HIB) else $error("short toggle woke module");
  a_long_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r == rpt_pkg::ST_HIB && tog_fall && hi_cnt_r >= HI_MIN) |=>
    state_r == rpt_pkg::ST_BOOT ##1 wake_r) else $error("toggle ignored");
  a_sleep_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (is_ready && tog_fall && hi_cnt_r >= HI_MIN) |=>
    state_r == rpt_pkg::ST_HIB && !wake_indication_output) else $error("sleep toggle ignored");
  a_ready_report: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_r == rpt_pkg::ST_READY) |-> pend_r[rpt_pkg::P_READY])
    else $error("ready report missing");
  // command handshake and outcome
  a_sbas_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd_take && is_ready && cmd_in.binary && !cmd_in.beacon
     && cmd_in.id == rpt_pkg::BIN_SBAS_CTRL) |=> sbas_enabled && pend_r[rpt_pkg::P_ACK])
    else $error("augmentation not enabled");
  a_text_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd_take && is_ready && !cmd_in.binary && !cmd_in.beacon
     && cmd_in.id == rpt_pkg::TXT_NAV_LLA) |=> cmd_class_vld
     && cmd_class == rpt_pkg::CLS_NAV_LLA) else $error("text decode wrong");
  a_ee_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd_take && is_ready && !cmd_in.binary && !cmd_in.beacon
     && cmd_in.id == rpt_pkg::TXT_EE_DEBUG) |=> cmd_class == rpt_pkg::CLS_EE_DEBUG)
    else $error("ephemeris decode wrong");
  a_beacon_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd_take && is_ready && cmd_in.beacon) |=> cmd_class == rpt_pkg::CLS_BEACON)
    else $error("beacon command lost");
  a_err_asleep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd_take && !is_ready) |=> pend_r[rpt_pkg::P_ERR] && !cmd_ready)
    else $error("error report missing");
  a_nak_unknown: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmd_take && is_ready && cmd_in.binary && !cmd_in.beacon
     && cmd_in.id != rpt_pkg::BIN_SBAS_CTRL) |=> cmd_class == rpt_pkg::CLS_NONE
     && pend_r[rpt_pkg::P_NAK]) else $error("unknown command not rejected");
  a_cmd_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_take |=> !cmd_ready)
    else $error("command taken while outcome pending");
  // report stream
  a_fix_reports: assert property (@(posedge core_clk) disable iff (!rst_n)
    (is_ready && fix_evt) |=> pend_r[rpt_pkg::P_NAV] && pend_r[rpt_pkg::P_GEO])
    else $error("fix reports missing");
  a_fix_asleep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r == rpt_pkg::ST_HIB && fix_evt && !pend_r[rpt_pkg::P_NAV]) |=>
    !pend_r[rpt_pkg::P_NAV]) else $error("report raised while asleep");
  a_rpt_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rpt_valid && !rpt_ready) |=> rpt_valid && $stable(rpt_id))
    else $error("stalled report changed");
  a_track_reports: assert property (@(posedge core_clk) disable iff (!rst_n)
    (is_ready && track_evt) |=> pend_r[rpt_pkg::P_TRACK] && pend_r[rpt_pkg::P_VISIBLE])
    else $error("track reports missing");
  a_pps_reports: assert property (@(posedge core_clk) disable iff (!rst_n)
    (is_ready && pps_evt && sbas_r) |=> pend_r[rpt_pkg::P_PPS] && pend_r[rpt_pkg::P_SBAS])
    else $error("pps reports missing");
  a_pps_plain: assert property (@(posedge core_clk) disable iff (!rst_n)
    (is_ready && pps_evt && !sbas_r && !pend_r[rpt_pkg::P_SBAS]) |=>
    pend_r[rpt_pkg::P_PPS] && !pend_r[rpt_pkg::P_SBAS]) else $error("pps reports wrong");
  a_corr_reports: assert property (@(posedge core_clk) disable iff (!rst_n)
    (is_ready && corr_evt) |=> pend_r[rpt_pkg::P_CORR] && pend_r[rpt_pkg::P_CORR_STAT])
    else $error("correction reports missing");

  c_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_r == rpt_pkg::ST_READY));
  c_sleep: cover property (@(posedge core_clk) disable iff (!rst_n)
    is_ready && pulse_ok ##1 state_r == rpt_pkg::ST_HIB);
  c_ack_out: cover property (@(posedge core_clk) disable iff (!rst_n)
    rpt_valid && rpt_ready && rpt_id == rpt_pkg::OUT_ACK);
  c_stall_full: cover property (@(posedge core_clk) disable iff (!rst_n)
    !buf_in_ready && (|pend_r));
  c_err_out: cover property (@(posedge core_clk) disable iff (!rst_n)
    rpt_valid && rpt_ready && rpt_id == rpt_pkg::OUT_ERROR);
endmodule
`default_nettype wire

// *** verification/rpt_host_model.sv ***
`default_nettype none
module rpt_host_model (
  input wire logic core_clk, // bench clock
  input wire logic hold, // stall the report sink
  output logic power_toggle, // toggle pin to the module
  output logic rpt_ready // report sink ready
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    power_toggle = 1'b0;
  end

  // random stalls: a real host drains the port at its own pace
  always @(negedge core_clk) begin
    rpt_ready <= !hold && ($urandom_range(3, 0) != 0);
  end

  // width in whole cycles, rounded up by the caller; the low tail keeps pulses apart
  task automatic send_pulse(input int cyc);
    @(negedge core_clk);
    power_toggle = 1'b1;
    repeat (cyc) @(negedge core_clk);
    power_toggle = 1'b0;
    repeat (5) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// *** verification/receiver_power_toggle_and_message_ids_test.sv ***
`default_nettype none
module receiver_power_toggle_and_message_ids_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PULSE = rpt_pkg::TOGGLE_MIN_CYC + 5;
  logic core_clk, rst_n, cmd_valid, hold, power_toggle, rpt_ready, wake;
  logic fix_evt, track_evt, pps_evt, corr_evt;
  logic cmd_ready, cmd_class_vld, sbas_enabled, rpt_valid;
  rpt_pkg::rpt_cmd_t cmd_in;
  rpt_pkg::rpt_class_t cmd_class;
  logic [7:0] rpt_id;
  logic [7:0] exp_q[$];
  int fails, tests_run;

  rpt_power_seq #(.STARTUP_CYC(2)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .power_toggle(power_toggle),
    .wake_indication_output(wake), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_in(cmd_in), .cmd_class(cmd_class), .cmd_class_vld(cmd_class_vld),
    .sbas_enabled(sbas_enabled), .fix_evt(fix_evt), .track_evt(track_evt),
    .pps_evt(pps_evt), .corr_evt(corr_evt), .rpt_valid(rpt_valid),
    .rpt_ready(rpt_ready), .rpt_id(rpt_id));

  rpt_host_model i_host (.core_clk(core_clk), .hold(hold), .power_toggle(power_toggle),
    .rpt_ready(rpt_ready));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      fails++;
      results();
    end
  endtask

  task automatic cmd(input logic bin, input logic bcn, input logic [7:0] id,
                     input logic [3:0] cls, input logic [7:0] rep, input logic up);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      fails++;
      results();
    end
    cmd_in = {bin, bcn, id};
    cmd_valid = 1'b1;
    exp_q.push_back(rep);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    check("cmd_ready", {7'h0, cmd_ready}, 8'h0);
    check("cmd_class_vld", {7'h0, cmd_class_vld}, {7'h0, up});
    if (up) begin
      check("cmd_class", {4'h0, cmd_class}, {4'h0, cls});
    end
  endtask

  task automatic evt(input logic [3:0] sel);
    {fix_evt, track_evt, pps_evt, corr_evt} = sel;
    @(negedge core_clk);
    {fix_evt, track_evt, pps_evt, corr_evt} = 4'h0;
  endtask

  // results are matched in the order the buffer hands them out
  always @(posedge core_clk) begin
    if (rst_n === 1'b1 && rpt_valid === 1'b1 && rpt_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("rpt_id", rpt_id, 8'hxx);
      end else begin
        check("rpt_id", rpt_id, exp_q.pop_front());
      end
    end
  end

  initial begin
    logic [7:0] id;
    rpt_pkg::rpt_class_t tbl[11];
    tbl = '{rpt_pkg::CLS_SET_PORT, rpt_pkg::CLS_NAV_XYZ, rpt_pkg::CLS_CORR_PORT,
      rpt_pkg::CLS_RATE, rpt_pkg::CLS_NAV_LLA, rpt_pkg::CLS_DEV_DATA, rpt_pkg::CLS_DATUM,
      rpt_pkg::CLS_EE_PROP, rpt_pkg::CLS_EE_PROP, rpt_pkg::CLS_NONE, rpt_pkg::CLS_EE_DEBUG};
    fails = 0;
    tests_run = 0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_in = '0;
    hold = 1'b0;
    {fix_evt, track_evt, pps_evt, corr_evt} = 4'h0;
    id = 8'($urandom(32'ha7f3a68a));
    wait_cyc(3);
    check("wake", {7'h0, wake}, 8'h0);
    rst_n = 1'b1;
    wait_cyc(2);
    check("cmd_ready", {7'h0, cmd_ready}, 8'h1);
    check("rpt_valid", {7'h0, rpt_valid}, 8'h0);
    check("cmd_class", {4'h0, cmd_class}, 8'h0);
    // hibernating: command refused with an error report
    cmd(1'b0, 1'b0, rpt_pkg::TXT_SET_PORT, 4'h0, rpt_pkg::OUT_ERROR, 1'b0);
    drain();
    i_host.send_pulse(rpt_pkg::TOGGLE_MIN_CYC - 20);
    wait_cyc(10);
    check("wake", {7'h0, wake}, 8'h0);
    exp_q.push_back(rpt_pkg::OUT_READY);
    i_host.send_pulse(PULSE);
    wait_cyc(3);
    check("wake", {7'h0, wake}, 8'h1);
    drain();
    for (int i = 0; i < 11; i++) begin
      id = 8'h64 + 8'(i);
      cmd(1'b0, 1'b0, id, tbl[i], (tbl[i] == rpt_pkg::CLS_NONE) ? rpt_pkg::OUT_NAK :
          rpt_pkg::OUT_ACK, 1'b1);
    end
    id = 8'h6f + 8'($urandom_range(15, 0));
    cmd(1'b0, 1'b0, id, rpt_pkg::CLS_NONE, rpt_pkg::OUT_NAK, 1'b1);
    cmd(1'b1, 1'b0, 8'h86, rpt_pkg::CLS_NONE, rpt_pkg::OUT_NAK, 1'b1);
    cmd(1'b0, 1'b1, id, rpt_pkg::CLS_BEACON, rpt_pkg::OUT_ACK, 1'b1);
    drain();
    check("sbas_enabled", {7'h0, sbas_enabled}, 8'h0);
    exp_q.push_back(rpt_pkg::OUT_PPS);
    evt(4'h2);
    drain();
    cmd(1'b1, 1'b0, rpt_pkg::BIN_SBAS_CTRL, rpt_pkg::CLS_SBAS_ON, rpt_pkg::OUT_ACK,
        1'b1);
    drain();
    check("sbas_enabled", {7'h0, sbas_enabled}, 8'h1);
    exp_q = '{rpt_pkg::OUT_PPS, rpt_pkg::OUT_SBAS, rpt_pkg::OUT_CORR, rpt_pkg::OUT_CORR_STAT};
    evt(4'h3);
    drain();
    // stalled sink: two of the four reports fill the buffer and two back up behind it, none lost
    hold = 1'b1;
    wait_cyc(2);
    exp_q = '{rpt_pkg::OUT_NAV, rpt_pkg::OUT_GEO, rpt_pkg::OUT_TRACK, rpt_pkg::OUT_VISIBLE};
    evt(4'hc);
    wait_cyc(20);
    check("rpt_valid", {7'h0, rpt_valid}, 8'h1);
    check("rpt_id", rpt_id, rpt_pkg::OUT_NAV);
    hold = 1'b0;
    drain();
    i_host.send_pulse(PULSE);
    check("wake", {7'h0, wake}, 8'h0);
    evt(4'h8);
    wait_cyc(20);
    check("rpt_valid", {7'h0, rpt_valid}, 8'h0);
    results();
  end
endmodule
`default_nettype wire
